// ### pkg/xfer_pkg.sv
// Shared constants for the host select and buffer flag bridge
package xfer_pkg;
	localparam int WORD_W = 36;
	localparam int MID_W = 18;
	localparam int SMALL_W = 12;
	localparam int MAIN_SEL_W = 7;
	localparam int MID_CODE_W = 6;
	localparam int SMALL_CODE_W = 6;
	localparam int STAT_W = 13;
	// Main select code octal 014, bits 3 to 9
	localparam logic [6:0] MAIN_DEV_CODE = 7'h0c;
	// Mid host device code octal 22
	localparam logic [5:0] MID_DEV_CODE = 6'h12;
	// Small host codes: shared high octal digit, three low digits
	localparam logic [2:0] SMALL_HI_DIGIT = 3'h7;
	localparam logic [2:0] SMALL_LO0 = 3'h0;
	localparam logic [2:0] SMALL_LO1 = 3'h1;
	localparam logic [2:0] SMALL_LO2 = 3'h2;
	// Word bit n sits at vector index 35-n
	localparam int POS_SELF_CLR = 12;
	localparam int POS_SELF_SET = 11;
	localparam int POS_OFULL_CLR = 10;
	localparam int POS_OFULL_SET = 9;
	localparam int POS_OEMPTY_CLR = 8;
	localparam int POS_OEMPTY_SET = 7;
	localparam int POS_IFULL_CLR = 6;
	localparam int POS_IFULL_SET = 5;
	localparam int POS_IEMPTY_CLR = 4;
	localparam int POS_IEMPTY_SET = 3;
	localparam int POS_PI_HI = 2;
	localparam int POS_PI_LO = 0;
	localparam logic [2:0] PI_RESET = 3'h0;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [35:0] WORD_RESET = 36'h000000000;
	typedef enum logic [1:0] {SD_LOW, SD_HIGH, SD_TST_IFULL, SD_TST_OFULL} subdev_t;
endpackage : xfer_pkg

// ### pkg/sel_if.sv
// Decoded host selections passed from the decoder to the flag core
`timescale 1ns/1ps
`default_nettype none
interface sel_if;
	logic       main_sel;
	logic       mid_sel;
	logic       small_sel;
	logic [1:0] mid_sd;
	logic [1:0] small_idx;
	modport dec (output main_sel, output mid_sel, output small_sel, output mid_sd,
		output small_idx);
	modport use_side (input main_sel, input mid_sel, input small_sel, input mid_sd,
		input small_idx);
endinterface : sel_if
`default_nettype wire

// ### core/host_select.sv
// Device code decoding for the three hosts
`timescale 1ns/1ps
`default_nettype none
module host_select #(
	parameter logic [2:0] SMALL_HI = xfer_pkg::SMALL_HI_DIGIT,
	parameter logic [2:0] SMALL_C0 = xfer_pkg::SMALL_LO0,
	parameter logic [2:0] SMALL_C1 = xfer_pkg::SMALL_LO1,
	parameter logic [2:0] SMALL_C2 = xfer_pkg::SMALL_LO2
) (
	input  wire logic [6:0] main_sel_true_i,
	input  wire logic [6:0] main_sel_comp_i,
	input  wire logic [7:0] mid_instr_i,
	input  wire logic [5:0] small_instr_i,
	sel_if.dec              sel
);
	function automatic logic small_hit(input logic [5:0] f, input logic [2:0] lo);
		small_hit = (f == {SMALL_HI, lo});
	endfunction : small_hit

	logic main_pairs_ok;

	// Broken pair on the cable must not select
	assign main_pairs_ok = (main_sel_true_i == ~main_sel_comp_i);
	assign sel.main_sel = main_pairs_ok && (main_sel_true_i == xfer_pkg::MAIN_DEV_CODE);
	// Bits 6..11 code, bits 12..13 subdevice
	assign sel.mid_sel = (mid_instr_i[7:2] == xfer_pkg::MID_DEV_CODE);
	assign sel.mid_sd = mid_instr_i[1:0];
	// One shared high digit keeps the three codes in one triad
	assign sel.small_sel = small_hit(small_instr_i, SMALL_C0)
		|| small_hit(small_instr_i, SMALL_C1)
		|| small_hit(small_instr_i, SMALL_C2);
	assign sel.small_idx = small_hit(small_instr_i, SMALL_C1) ? 2'h1 :
		(small_hit(small_instr_i, SMALL_C2) ? 2'h2 : 2'h0);
endmodule : host_select
`default_nettype wire

// ### core/bridge_flags.sv
// Bridge core: host selection, buffers and flags
`timescale 1ns/1ps
`default_nettype none
module bridge_flags #(
	parameter logic [2:0] SMALL_HI = xfer_pkg::SMALL_HI_DIGIT,
	parameter logic [2:0] SMALL_C0 = xfer_pkg::SMALL_LO0,
	parameter logic [2:0] SMALL_C1 = xfer_pkg::SMALL_LO1,
	parameter logic [2:0] SMALL_C2 = xfer_pkg::SMALL_LO2
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [6:0]  main_sel_true_i,
	input  wire logic [6:0]  main_sel_comp_i,
	input  wire logic        data_write_clr_i,
	input  wire logic        data_write_set_i,
	input  wire logic        data_read_i,
	input  wire logic        control_write_clr_i,
	input  wire logic        control_write_set_i,
	input  wire logic        status_read_i,
	input  wire logic [35:0] main_data_i,
	output logic      [35:0] main_data_o,
	output logic             main_irq_o,
	output logic      [2:0]  pi_channel_o,
	input  wire logic [7:0]  mid_instr_i,
	input  wire logic [2:0]  mid_pulse_i,
	input  wire logic [17:0] mid_ac_i,
	output logic      [17:0] mid_ac_o,
	output logic             mid_skip_o,
	input  wire logic [5:0]  small_instr_i,
	input  wire logic [2:0]  small_pulse_i,
	input  wire logic [11:0] small_ac_i,
	output logic      [11:0] small_ac_o,
	output logic             small_skip_o,
	output logic             mini_irq_o,
	output logic             sel_main_o,
	output logic             sel_mid_o,
	output logic             sel_small_o,
	output logic             self_check_o,
	output logic             outbound_full_flag_o,
	output logic             outbound_empty_flag_o,
	output logic             inbound_full_flag_o,
	output logic             inbound_empty_flag_o,
	output logic      [35:0] outbound_buffer_o,
	output logic      [35:0] inbound_buffer_o
);
	sel_if sel ();

	host_select #(
		.SMALL_HI (SMALL_HI),
		.SMALL_C0 (SMALL_C0),
		.SMALL_C1 (SMALL_C1),
		.SMALL_C2 (SMALL_C2)
	) u_sel (
		.main_sel_true_i (main_sel_true_i),
		.main_sel_comp_i (main_sel_comp_i),
		.mid_instr_i     (mid_instr_i),
		.small_instr_i   (small_instr_i),
		.sel             (sel.dec)
	);

	logic [35:0] outbound_buffer_r;
	logic [35:0] inbound_buffer_r;
	logic        ofull_r;
	logic        oempty_r;
	logic        ifull_r;
	logic        iempty_r;
	logic [2:0]  pi_r;
	logic        self_r;
	logic [35:0] main_data_r;
	logic [17:0] mid_ac_r;
	logic [11:0] small_ac_r;

	// Main strobes, all gated by the decoded code
	logic m_dw_clr, m_dw_set, m_dr, m_cw_clr, m_cw_set, m_sr;
	assign m_dw_clr = sel.main_sel && data_write_clr_i;
	assign m_dw_set = sel.main_sel && data_write_set_i;
	assign m_dr = sel.main_sel && data_read_i;
	assign m_cw_clr = sel.main_sel && control_write_clr_i;
	assign m_cw_set = sel.main_sel && control_write_set_i;
	assign m_sr = sel.main_sel && status_read_i;

	// Mid host strobes: subdevice and pulse
	logic d_p1, d_p2, d_p4;
	assign d_p1 = sel.mid_sel && mid_pulse_i[0];
	assign d_p2 = sel.mid_sel && mid_pulse_i[1];
	assign d_p4 = sel.mid_sel && mid_pulse_i[2];
	logic d_iclr, d_rd_lo, d_rd_hi, d_ld_lo, d_ld_hi;
	assign d_iclr = d_p1 && (sel.mid_sd == 2'(xfer_pkg::SD_LOW));
	assign d_rd_lo = d_p2 && (sel.mid_sd == 2'(xfer_pkg::SD_LOW));
	assign d_rd_hi = d_p2 && (sel.mid_sd == 2'(xfer_pkg::SD_HIGH));
	assign d_ld_lo = d_p4 && (sel.mid_sd == 2'(xfer_pkg::SD_LOW));
	assign d_ld_hi = d_p4 && (sel.mid_sd == 2'(xfer_pkg::SD_HIGH));

	// Small host strobes: code index and pulse
	logic s_p1, s_p2, s_p4;
	assign s_p1 = sel.small_sel && small_pulse_i[0];
	assign s_p2 = sel.small_sel && small_pulse_i[1];
	assign s_p4 = sel.small_sel && small_pulse_i[2];
	logic s_iclr, s_last_rd, s_last_ld;
	assign s_iclr = s_p1 && (sel.small_idx == 2'h1);
	assign s_last_rd = s_p2 && (sel.small_idx == 2'h2);
	assign s_last_ld = s_p4 && (sel.small_idx == 2'h2);

	logic in_clear, last_byte_out, last_byte_in;
	assign in_clear = d_iclr || s_iclr;
	assign last_byte_out = d_rd_hi || s_last_rd;
	assign last_byte_in = d_ld_hi || s_last_ld;

	always_comb begin
		mid_skip_o = 1'b0;
		if (d_p1) begin
			case (sel.mid_sd)
				2'(xfer_pkg::SD_HIGH): mid_skip_o = iempty_r;
				2'(xfer_pkg::SD_TST_IFULL): mid_skip_o = ifull_r;
				2'(xfer_pkg::SD_TST_OFULL): mid_skip_o = ofull_r;
				default: mid_skip_o = 1'b0;
			endcase
		end
	end

	always_comb begin
		small_skip_o = 1'b0;
		if (s_p1 && sel.small_idx == 2'h0) begin
			small_skip_o = iempty_r;
		end else if (s_p1 && sel.small_idx == 2'h2) begin
			small_skip_o = ofull_r;
		end
	end

	// Outbound buffer: main loads, cleared first by the clear pulse
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			outbound_buffer_r <= xfer_pkg::WORD_RESET;
		end else if (m_dw_set) begin
			outbound_buffer_r <= main_data_i;
		end else if (m_dw_clr) begin
			outbound_buffer_r <= xfer_pkg::WORD_RESET;
		end
	end

	// Inbound buffer assembled byte by byte
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			inbound_buffer_r <= xfer_pkg::WORD_RESET;
		end else if (in_clear) begin
			inbound_buffer_r <= xfer_pkg::WORD_RESET;
		end else begin
			if (d_ld_lo) begin
				inbound_buffer_r[35:18] <= mid_ac_i;
			end
			if (d_ld_hi) begin
				inbound_buffer_r[17:0] <= mid_ac_i;
			end
			if (s_p4) begin
				case (sel.small_idx)
					2'h0: inbound_buffer_r[35:24] <= small_ac_i;
					2'h1: inbound_buffer_r[23:12] <= small_ac_i;
					default: inbound_buffer_r[11:0] <= small_ac_i;
				endcase
			end
		end
	end

	// Flags: any set beats any clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ofull_r  <= xfer_pkg::FLAG_RESET;
			oempty_r <= xfer_pkg::FLAG_RESET;
			ifull_r  <= xfer_pkg::FLAG_RESET;
			iempty_r <= xfer_pkg::FLAG_RESET;
		end else begin
			if (m_dw_set || (m_cw_set && main_data_i[xfer_pkg::POS_OFULL_SET])) begin
				ofull_r <= 1'b1;
			end else if (last_byte_out
				|| (m_cw_clr && main_data_i[xfer_pkg::POS_OFULL_CLR])) begin
				ofull_r <= 1'b0;
			end
			if (last_byte_out || (m_cw_set && main_data_i[xfer_pkg::POS_OEMPTY_SET])) begin
				oempty_r <= 1'b1;
			end else if (m_dw_clr || (m_cw_clr && main_data_i[xfer_pkg::POS_OEMPTY_CLR])) begin
				oempty_r <= 1'b0;
			end
			if (last_byte_in || (m_cw_set && main_data_i[xfer_pkg::POS_IFULL_SET])) begin
				ifull_r <= 1'b1;
			end else if (m_dr || (m_cw_clr && main_data_i[xfer_pkg::POS_IFULL_CLR])) begin
				ifull_r <= 1'b0;
			end
			if (m_dr || (m_cw_set && main_data_i[xfer_pkg::POS_IEMPTY_SET])) begin
				iempty_r <= 1'b1;
			end else if (in_clear || (m_cw_clr && main_data_i[xfer_pkg::POS_IEMPTY_CLR])) begin
				iempty_r <= 1'b0;
			end
		end
	end

	// Channel cleared by the first half, ORed in by the second
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pi_r   <= xfer_pkg::PI_RESET;
			self_r <= xfer_pkg::FLAG_RESET;
		end else begin
			if (m_cw_set) begin
				pi_r <= pi_r | main_data_i[xfer_pkg::POS_PI_HI:xfer_pkg::POS_PI_LO];
			end else if (m_cw_clr) begin
				pi_r <= xfer_pkg::PI_RESET;
			end
			if (m_cw_set && main_data_i[xfer_pkg::POS_SELF_SET]) begin
				self_r <= 1'b1;
			end else if (m_cw_clr && main_data_i[xfer_pkg::POS_SELF_CLR]) begin
				self_r <= 1'b0;
			end
		end
	end

	// Main read word: data read or status read
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			main_data_r <= xfer_pkg::WORD_RESET;
		end else if (m_dr) begin
			main_data_r <= inbound_buffer_r;
		end else if (m_sr) begin
			main_data_r <= xfer_pkg::WORD_RESET;
			main_data_r[xfer_pkg::POS_SELF_SET] <= self_r;
			main_data_r[xfer_pkg::POS_OFULL_SET] <= ofull_r;
			main_data_r[xfer_pkg::POS_OEMPTY_SET] <= oempty_r;
			main_data_r[xfer_pkg::POS_IFULL_SET] <= ifull_r;
			main_data_r[xfer_pkg::POS_IEMPTY_SET] <= iempty_r;
			main_data_r[xfer_pkg::POS_PI_HI:xfer_pkg::POS_PI_LO] <= pi_r;
		end
	end

	// Mini read words hold until the next read
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			mid_ac_r   <= 18'h00000;
			small_ac_r <= 12'h000;
		end else begin
			if (d_rd_lo) begin
				mid_ac_r <= outbound_buffer_r[35:18];
			end else if (d_rd_hi) begin
				mid_ac_r <= outbound_buffer_r[17:0];
			end
			if (s_p2) begin
				case (sel.small_idx)
					2'h0: small_ac_r <= outbound_buffer_r[35:24];
					2'h1: small_ac_r <= outbound_buffer_r[23:12];
					default: small_ac_r <= outbound_buffer_r[11:0];
				endcase
			end
		end
	end

	assign main_data_o = main_data_r;
	assign mid_ac_o = mid_ac_r;
	assign small_ac_o = small_ac_r;
	assign pi_channel_o = pi_r;
	// Channel zero means main interrupt off; the mini interrupt ignores the channel
	assign main_irq_o = (oempty_r || ifull_r) && (pi_r != xfer_pkg::PI_RESET);
	assign mini_irq_o = ofull_r || iempty_r;
	assign sel_main_o = sel.main_sel;
	assign sel_mid_o = sel.mid_sel;
	assign sel_small_o = sel.small_sel;
	assign self_check_o = self_r;
	assign outbound_full_flag_o = ofull_r;
	assign outbound_empty_flag_o = oempty_r;
	assign inbound_full_flag_o = ifull_r;
	assign inbound_empty_flag_o = iempty_r;
	assign outbound_buffer_o = outbound_buffer_r;
	assign inbound_buffer_o = inbound_buffer_r;
endmodule : bridge_flags
`default_nettype wire

// ### testbench/main_host_model.sv
// Main host side model: device select sent as true and complement pairs
`timescale 1ns/1ps
`default_nettype none
module main_host_model (
	input  wire logic [6:0] code_i,
	input  wire logic       bad_pair_i,
	output logic      [6:0] sel_true_o,
	output logic      [6:0] sel_comp_o
);
	// Broken pair makes one rail agree with its true line
	assign sel_true_o = code_i;
	assign sel_comp_o = ~code_i ^ {6'h00, bad_pair_i};
endmodule : main_host_model
`default_nettype wire

// ### testbench/bridge_flags_assertions.sv
// Port level checker for the bridge core
`timescale 1ns/1ps
`default_nettype none
module bridge_flags_checker (
	input wire logic        sys_clk_i,
	input wire logic        rst_n_i,
	input wire logic [6:0]  main_sel_true_i,
	input wire logic [6:0]  main_sel_comp_i,
	input wire logic        data_write_set_i,
	input wire logic        data_read_i,
	input wire logic        control_write_clr_i,
	input wire logic        control_write_set_i,
	input wire logic        status_read_i,
	input wire logic [35:0] main_data_i,
	input wire logic [35:0] main_data_o,
	input wire logic [2:0]  pi_channel_o,
	input wire logic [7:0]  mid_instr_i,
	input wire logic [2:0]  mid_pulse_i,
	input wire logic [2:0]  small_pulse_i,
	input wire logic        mini_irq_o,
	input wire logic        sel_main_o,
	input wire logic        sel_mid_o,
	input wire logic        outbound_full_flag_o,
	input wire logic        inbound_full_flag_o,
	input wire logic        inbound_empty_flag_o,
	input wire logic [35:0] outbound_buffer_o,
	input wire logic [35:0] inbound_buffer_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Other hosts idle and no main control set, so set-beats-clear cannot mask a result
	logic quiet;
	assign quiet = mid_pulse_i == 3'h0 && small_pulse_i == 3'h0 && !control_write_set_i;
	mini_irq_a: assert property (mini_irq_o == (outbound_full_flag_o | inbound_empty_flag_o))
		else $error("mini interrupt wrong");
	main_sel_a: assert property (sel_main_o == (main_sel_true_i == 7'h0c &&
		main_sel_comp_i == ~main_sel_true_i)) else $error("main select wrong");
	mid_sel_a: assert property (sel_mid_o == (mid_instr_i[7:2] == 6'h12))
		else $error("mid select wrong");
	write_load_a: assert property (data_write_set_i && sel_main_o && quiet |=>
		outbound_full_flag_o && outbound_buffer_o == $past(main_data_i)) else $error("load wrong");
	read_ret_a: assert property (data_read_i && sel_main_o && quiet && !status_read_i |=>
		inbound_empty_flag_o && !inbound_full_flag_o && main_data_o == $past(inbound_buffer_o))
		else $error("main read wrong");
	unsel_quiet_a: assert property (data_read_i && !sel_main_o && quiet && !status_read_i |=>
		$stable(main_data_o) && $stable(inbound_empty_flag_o)) else $error("unselected acted");
	ctl_empty_a: assert property (control_write_set_i && sel_main_o && main_data_i[3] |=>
		inbound_empty_flag_o) else $error("control empty set missed");
	chan_set_a: assert property (control_write_set_i && sel_main_o && !control_write_clr_i |=>
		pi_channel_o == ($past(pi_channel_o) | $past(main_data_i[2:0]))) else $error("channel wrong");
endmodule : bridge_flags_checker
bind bridge_flags bridge_flags_checker i_chk (.*);
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the host select and flag bridge
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        sys_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [11:0] pl = 12'h000;
	logic [6:0]  code = 7'h0c;
	logic [6:0]  main_sel_true_i, main_sel_comp_i;
	logic        bad = 1'b0;
	logic [35:0] main_data_i = 36'h0, main_data_o, outbound_buffer_o, inbound_buffer_o, d, e;
	logic [7:0]  mid_instr_i = 8'h00;
	logic [17:0] mid_ac_i = 18'h0, mid_ac_o;
	logic [5:0]  small_instr_i = 6'h00;
	logic [11:0] small_ac_i = 12'h0, small_ac_o;
	logic [2:0]  pi_channel_o;
	logic        main_irq_o, mid_skip_o, small_skip_o, mini_irq_o, sel_main_o, sel_mid_o;
	logic        sel_small_o, self_check_o, outbound_full_flag_o, outbound_empty_flag_o;
	logic        inbound_full_flag_o, inbound_empty_flag_o;
	logic [1:0]  sk;
	logic [15:0] lfsr = 16'h4237;
	int          failures = 0, comparisons = 0, cyc = 0, i, k;
	wire  [3:0]  fl = {outbound_full_flag_o, outbound_empty_flag_o, inbound_full_flag_o,
		inbound_empty_flag_o};
	main_host_model i_host (.code_i(code), .bad_pair_i(bad), .sel_true_o(main_sel_true_i),
		.sel_comp_o(main_sel_comp_i));
	bridge_flags i_dut (.*, .data_write_clr_i(pl[0]), .data_write_set_i(pl[1]),
		.data_read_i(pl[2]), .control_write_clr_i(pl[3]), .control_write_set_i(pl[4]),
		.status_read_i(pl[5]), .mid_pulse_i(pl[8:6]), .small_pulse_i(pl[11:9]));
	always #20 sys_clk_i = ~sys_clk_i;
	function automatic logic [35:0] rnd();
		for (int n = 0; n < 36; n++) begin
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			rnd[n] = lfsr[0];
		end
	endfunction : rnd
	// Status word: self, ofull, oempty, ifull, iempty, then channel
	function automatic logic [35:0] stw(input logic [4:0] f, input logic [2:0] c);
		return {24'h0, f[4], 1'b0, f[3], 1'b0, f[2], 1'b0, f[1], 1'b0, f[0], c};
	endfunction : stw
	// Wide enough for both buffers side by side, so no check loses its top bits
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle pulse; skip outputs are only valid while it is high
	task automatic pls(input int n);
		@(negedge sys_clk_i);
		pl[n] = 1'b1;
		#1 sk = {mid_skip_o, small_skip_o};
		@(negedge sys_clk_i);
		pl = 12'h000;
	endtask : pls
	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (8) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		for (i = 0; i < 24; i++) begin
			@(negedge sys_clk_i);
			d = rnd();
			code = (i < 2) ? 7'h0c : d[6:0];
			bad = (i == 1);
			mid_instr_i = (i == 0) ? 8'h48 : d[14:7];
			small_instr_i = (i < 4) ? {3'h7, i[2:0]} : d[20:15];
			#1 chk(sel_main_o, code == 7'h0c && !bad);
			chk(sel_mid_o, mid_instr_i[7:2] == 6'h12);
			chk(sel_small_o, small_instr_i[5:3] == 3'h7 && small_instr_i[2:0] < 3'h3);
		end
		code = 7'h0c;
		bad = 1'b0;
		main_data_i = stw(5'h1f, 3'h5);
		pls(3);
		pls(4);
		chk(fl, 4'hf);
		chk({mini_irq_o, main_irq_o, pi_channel_o}, 5'h1d);
		pls(5);
		chk(main_data_o, stw(5'h1f, 3'h5));
		main_data_i = stw(5'h1f, 3'h0) << 1;
		pls(3);
		chk({fl, self_check_o, pi_channel_o}, 8'h00);
		for (k = 0; k < 4; k++) begin
			d = (k == 0) ? 36'hfffffffff : rnd();
			main_data_i = d;
			pls(0);
			chk(outbound_buffer_o, 36'h0);
			pls(1);
			chk(outbound_buffer_o, d);
			chk({outbound_full_flag_o, mini_irq_o}, 2'h3);
			mid_instr_i = 8'h48;
			pls(7);
			chk(mid_ac_o, d[35:18]);
			mid_instr_i = 8'h49;
			pls(7);
			chk({mid_ac_o, fl[3:2]}, {d[17:0], 2'h1});
			mid_instr_i = 8'h4b;
			pls(6);
			chk(sk[1], 1'b0);
			e = rnd();
			mid_instr_i = 8'h48;
			pls(6);
			chk({inbound_buffer_o, fl[0]}, 37'h0);
			mid_ac_i = e[35:18];
			pls(8);
			mid_instr_i = 8'h49;
			mid_ac_i = e[17:0];
			pls(8);
			chk({inbound_buffer_o, fl[1]}, {e, 1'b1});
			mid_instr_i = 8'h4a;
			pls(6);
			chk(sk[1], 1'b1);
			mid_instr_i = 8'h49;
			pls(2);
			chk({main_data_o, fl[1:0]}, {e, 2'h1});
			pls(6);
			chk(sk[1], 1'b1);
		end
		code = 7'h0d;
		mid_instr_i = 8'h4d;
		main_data_i = ~d;
		mid_ac_i = ~e[17:0];
		pls(1);
		pls(8);
		pls(2);
		chk({outbound_buffer_o, inbound_buffer_o}, {d, e});
		code = 7'h0c;
		bad = 1'b1;
		pls(1);
		chk(outbound_buffer_o, d);
		bad = 1'b0;
		d = rnd();
		main_data_i = d;
		pls(0);
		pls(1);
		e = rnd();
		for (k = 0; k < 3; k++) begin
			small_instr_i = {3'h7, k[2:0]};
			small_ac_i = e[35-12*k -: 12];
			pls(11);
			pls(10);
			chk(small_ac_o, d[35-12*k -: 12]);
		end
		chk({inbound_buffer_o, fl}, {e, 4'h7});
		small_instr_i = 6'h3a;
		pls(9);
		chk(sk[0], 1'b0);
		small_instr_i = 6'h38;
		pls(9);
		chk(sk[0], 1'b1);
		small_instr_i = 6'h39;
		pls(9);
		chk({inbound_buffer_o, fl[0]}, 37'h0);
		close_out();
	end
endmodule : testbench
`default_nettype wire
